// *** common/nvram_ctl_pkg.sv ***
// constants and types for the serial nonvolatile memory control slice
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
package nvram_ctl_pkg;

  // status byte layout, bit 7 down to bit 0
  typedef struct packed {
    logic statusProtectEnable; // bit 7, nonvolatile
    logic [2:0] spare;         // bits 6..4, nonvolatile, unused
    logic blockProtectHigh;    // bit 3, nonvolatile
    logic blockProtectLow;     // bit 2, nonvolatile
    logic writeEnableLatch;    // bit 1, volatile
    logic zero;                // bit 0, always zero
  } status_t;

  localparam status_t STATUS_RESET = 8'h00;

  // opcodes
  localparam logic [7:0] OPC_IDENTITY = 8'h9F;
  localparam logic [7:0] OPC_SLEEP = 8'hB9;

  // serial bit counts
  localparam logic [3:0] OPC_BITS = 4'h8;
  localparam logic [3:0] OPC_LAST = 4'h7;
  localparam logic [3:0] CNT_CAP = 4'h9;
  localparam logic [5:0] ID_BITS = 6'h20;
  localparam logic [4:0] ID_MSB = 5'h1F;

  // identity codes, values arbitrary
  localparam logic [7:0] ID_MAKER = 8'h5A;
  localparam logic [7:0] ID_CONT = 8'h7E;
  localparam logic [7:0] ID_PROD1 = 8'h12;
  localparam logic [7:0] ID_PROD2 = 8'h34;
  localparam logic [31:0] ID_WORD = {ID_MAKER, ID_CONT, ID_PROD1, ID_PROD2};

  // block protect start addresses
  localparam logic [15:0] QUARTER_BASE = 16'hC000;
  localparam logic [15:0] HALF_BASE = 16'h8000;

  // pin synchroniser order {armed, wpN, holdN, csN} and idle levels
  localparam logic [3:0] PIN_IDLE = 4'h7;
  localparam int PIN_CS = 0;
  localparam int PIN_HOLD = 1;
  localparam int PIN_WP = 2;
  localparam int PIN_ARMED = 3;

  // sleep recovery timing
  localparam int SLEEP_RECOVERY_US = 400;
  localparam int CLK_FREQ_MHZ = 100;
  localparam int WAKE_CYCLES = SLEEP_RECOVERY_US * CLK_FREQ_MHZ;
  localparam int SYNC_LAT = 4;

endpackage

// *** hw/spi_nvram_protect_sleep_hold.sv ***
// control slice: identity readout, sleep, write protection and hold
`timescale 1ns/1ps
module spi_nvram_protect_sleep_hold #(
  parameter int unsigned WakeCycles = nvram_ctl_pkg::WAKE_CYCLES
) (
  input wire logic clock, // system clock, 100 MHz
  input wire logic srst, // synchronous reset, active high
  input wire logic sclk, // serial clock from the host
  input wire logic csN, // chip select, active low
  input wire logic si, // serial data in
  input wire logic holdN, // hold pin, active low
  input wire logic wpN, // write protect pin, active low
  output logic soOut, // serial data out value
  output logic soOe, // serial data out enable
  input wire logic welSet, // pulse: set write enable latch
  input wire logic welClr, // pulse: clear write enable latch
  input wire logic statusWrReq, // pulse: status write request
  input wire nvram_ctl_pkg::status_t statusWrData, // status write data
  input wire logic memWrReq, // pulse: memory byte write request
  input wire logic [15:0] memWrAddr, // address of that byte
  output logic memWrStore, // pulse: byte may be stored
  output logic memWrDrop, // pulse: byte dropped, latch clear or protected
  output logic statusWrDone, // pulse: status written
  output logic statusWrDrop, // pulse: status write refused
  output nvram_ctl_pkg::status_t statusByte, // status register
  output logic sleeping, // level: asleep or waking
  output logic holdAbort // pulse: deselected during hold
);

  // width of the wake-up countdown
  localparam int WCW = $clog2(WakeCycles + 1);

  // ----------------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------------
  // the countdown load must not go below zero
  if (WakeCycles <= nvram_ctl_pkg::SYNC_LAT + 1) begin : g_bad_wake
    $error("WakeCycles too small for synchroniser latency");
  end

  // sleep states; WAKING spans the recovery interval
  typedef enum logic [1:0] {AWAKE, ASLEEP, WAKING} sleep_t;

  // registers that the link domain reads as resets
  logic rstLinkQ;
  logic sleepingQ;

  // reset handed to the link domain, asserted without a serial clock
  // the serial clock is idle while reset is applied, so release is calm
  always_ff @(posedge clock) begin
    rstLinkQ <= srst;
  end

  // ----------------------------------------------------------------------
  // link domain, clocked by the serial clock
  // ----------------------------------------------------------------------
  // frame logic clears on deselect, while asleep and during reset
  wire linkRst = csN | sleepingQ | rstLinkQ;
  wire armRst = sleepingQ | rstLinkQ;

  // link registers: bit count, opcode, sleep request, identity position
  logic [3:0] bitCntQ;
  logic [7:0] opcodeQ;
  logic armedQ;
  logic [5:0] idIdxQ;
  logic soOutQ;
  logic soOeQ;

  // opcode assembly and identity bit selection
  wire [7:0] opcodeD = {opcodeQ[6:0], si};
  wire opcodeLast = bitCntQ == nvram_ctl_pkg::OPC_LAST;
  wire idActive = (bitCntQ >= nvram_ctl_pkg::OPC_BITS) &&
                  (opcodeQ == nvram_ctl_pkg::OPC_IDENTITY);
  wire idMore = idIdxQ < nvram_ctl_pkg::ID_BITS;
  wire [4:0] idSel = nvram_ctl_pkg::ID_MSB - idIdxQ[4:0];

  // opcode shift on rising edges, frozen while hold is low
  // the count stops at nine so a long frame cannot wrap it
  always_ff @(posedge sclk or posedge linkRst) begin
    if (linkRst) begin
      bitCntQ <= 4'h0;
      opcodeQ <= 8'h00;
    end else if (holdN) begin
      if (bitCntQ < nvram_ctl_pkg::OPC_BITS) begin
        opcodeQ <= opcodeD;
      end
      if (bitCntQ != nvram_ctl_pkg::CNT_CAP) begin
        bitCntQ <= bitCntQ + 4'h1;
      end
    end
  end

  // sleep request: set by a whole sleep opcode, dropped by any later selected clock outside hold
  // it survives deselect so the system domain sees it with the select edge
  always_ff @(posedge sclk or posedge armRst) begin
    if (armRst) begin
      armedQ <= 1'b0;
    end else if (holdN && !csN) begin
      if (opcodeLast) begin
        armedQ <= opcodeD == nvram_ctl_pkg::OPC_SLEEP;
      end else begin
        armedQ <= 1'b0;
      end
    end
  end

  // identity shift on falling edges, last bit kept until deselect
  // a held falling edge floats the output and keeps the position
  always_ff @(negedge sclk or posedge linkRst) begin
    if (linkRst) begin
      idIdxQ <= 6'h00;
      soOutQ <= 1'b0;
      soOeQ <= 1'b0;
    end else if (!holdN) begin
      soOeQ <= 1'b0;
    end else if (idActive) begin
      soOeQ <= 1'b1;
      if (idMore) begin
        soOutQ <= nvram_ctl_pkg::ID_WORD[idSel];
        idIdxQ <= idIdxQ + 6'h01;
      end
    end
  end

  // serial output straight from the falling-edge registers
  assign soOut = soOutQ;
  assign soOe = soOeQ;

  // ----------------------------------------------------------------------
  // pin synchroniser into the system domain
  // ----------------------------------------------------------------------
  // stages one to three and the filtered level
  logic [3:0] s1Q;
  logic [3:0] s2Q;
  logic [3:0] s3Q;
  logic [3:0] pinQ;

  wire [3:0] syncIn = {armedQ, wpN, holdN, csN};
  wire [3:0] agree = ~(s2Q ^ s3Q);
  wire [3:0] pinD = (agree & s2Q) | (~agree & pinQ);

  // three stages; a change counts once stages two and three agree
  // the armed flag rides along so it reaches the edge detect in step
  always_ff @(posedge clock) begin
    if (srst) begin
      s1Q <= nvram_ctl_pkg::PIN_IDLE;
      s2Q <= nvram_ctl_pkg::PIN_IDLE;
      s3Q <= nvram_ctl_pkg::PIN_IDLE;
      pinQ <= nvram_ctl_pkg::PIN_IDLE;
    end else begin
      s1Q <= syncIn;
      s2Q <= s1Q;
      s3Q <= s2Q;
      pinQ <= pinD;
    end
  end

  // filtered pin levels and select edges
  logic csPrevQ;
  wire csS = pinQ[nvram_ctl_pkg::PIN_CS];
  wire holdS = pinQ[nvram_ctl_pkg::PIN_HOLD];
  wire wpS = pinQ[nvram_ctl_pkg::PIN_WP];
  wire armedS = pinQ[nvram_ctl_pkg::PIN_ARMED];
  wire csRise = csS & ~csPrevQ;
  wire csFall = ~csS & csPrevQ;

  // ----------------------------------------------------------------------
  // sleep state machine
  // ----------------------------------------------------------------------
  // state, wake-up countdown and the one-cycle wake strobe
  sleep_t stateQ;
  sleep_t stateD;
  logic [WCW-1:0] wakeCntQ;
  logic [WCW-1:0] wakeCntD;
  logic wakeDone;

  // countdown load: the select fall needs four edges through the
  // synchroniser and one more to reach the state register, and the
  // countdown ends one edge after it reaches zero; the return to normal
  // operation therefore lands at most WakeCycles edges after the fall
  localparam logic [WCW-1:0] WAKE_LOAD =
    WCW'(WakeCycles - nvram_ctl_pkg::SYNC_LAT - 2);

  // next state and wake-up countdown
  // a select rise with the request armed enters sleep
  always_comb begin
    stateD = stateQ;
    wakeCntD = wakeCntQ;
    wakeDone = 1'b0;
    case (stateQ)
      AWAKE: begin
        if (csRise && armedS) begin
          stateD = ASLEEP;
        end
      end
      ASLEEP: begin
        if (csFall) begin
          stateD = WAKING;
          wakeCntD = WAKE_LOAD;
        end
      end
      WAKING: begin
        if (wakeCntQ == '0) begin
          stateD = AWAKE;
          wakeDone = 1'b1;
        end else begin
          wakeCntD = wakeCntQ - 1'b1;
        end
      end
      default: begin
        stateD = AWAKE;
      end
    endcase
  end

  // state registers
  always_ff @(posedge clock) begin
    if (srst) begin
      stateQ <= AWAKE;
      wakeCntQ <= '0;
      sleepingQ <= 1'b0;
      csPrevQ <= 1'b1;
    end else begin
      stateQ <= stateD;
      wakeCntQ <= wakeCntD;
      sleepingQ <= stateD != AWAKE;
      csPrevQ <= csS;
    end
  end

  // asleep or still recovering
  assign sleeping = sleepingQ;

  // ----------------------------------------------------------------------
  // write protection and status register
  // ----------------------------------------------------------------------
  // status register and the registered answers
  nvram_ctl_pkg::status_t statusQ;
  logic memWrStoreQ;
  logic memWrDropQ;
  logic statusWrDoneQ;
  logic statusWrDropQ;
  logic holdAbortQ;

  // protect decode from the status bits, the address and the pin
  wire [1:0] bp = {statusQ.blockProtectHigh, statusQ.blockProtectLow};
  wire welOn = statusQ.writeEnableLatch;
  wire inQuarter = memWrAddr >= nvram_ctl_pkg::QUARTER_BASE;
  wire inHalf = memWrAddr >= nvram_ctl_pkg::HALF_BASE;
  wire addrProt = (bp == 2'h1 && inQuarter) ||
                  (bp == 2'h2 && inHalf) ||
                  (bp == 2'h3);
  wire memOk = welOn && !addrProt;
  wire statusOk = welOn &&
                  !(statusQ.statusProtectEnable && !wpS);
  wire abortNow = csRise && !holdS;

  // status and latch updates, wake clears the latch first
  // a set that meets a held deselect is dropped, keeping the old latch
  always_ff @(posedge clock) begin
    if (srst) begin
      statusQ <= nvram_ctl_pkg::STATUS_RESET;
    end else begin
      if (wakeDone) begin
        statusQ.writeEnableLatch <= 1'b0;
      end else if (welClr) begin
        statusQ.writeEnableLatch <= 1'b0;
      end else if (welSet && !abortNow) begin
        statusQ.writeEnableLatch <= 1'b1;
      end
      if (statusWrReq && statusOk) begin
        statusQ.statusProtectEnable <= statusWrData.statusProtectEnable;
        statusQ.spare <= statusWrData.spare;
        statusQ.blockProtectHigh <= statusWrData.blockProtectHigh;
        statusQ.blockProtectLow <= statusWrData.blockProtectLow;
      end
    end
  end

  // one-cycle answers to write requests and the hold abort
  // a protected byte is refused here; the datapath still moves on
  always_ff @(posedge clock) begin
    if (srst) begin
      memWrStoreQ <= 1'b0;
      memWrDropQ <= 1'b0;
      statusWrDoneQ <= 1'b0;
      statusWrDropQ <= 1'b0;
      holdAbortQ <= 1'b0;
    end else begin
      memWrStoreQ <= memWrReq && memOk;
      memWrDropQ <= memWrReq && !memOk;
      statusWrDoneQ <= statusWrReq && statusOk;
      statusWrDropQ <= statusWrReq && !statusOk;
      holdAbortQ <= abortNow;
    end
  end

  // outputs straight from their registers
  assign statusByte = statusQ;
  assign memWrStore = memWrStoreQ;
  assign memWrDrop = memWrDropQ;
  assign statusWrDone = statusWrDoneQ;
  assign statusWrDrop = statusWrDropQ;
  assign holdAbort = holdAbortQ;

endmodule

// *** bench/nvram_ctl_asserts.sv ***
// assertion checker for the nvram control slice
`timescale 1ns/1ps
module nvram_ctl_asserts #(
  parameter int unsigned WakeCycles = 20
) (
  input wire logic clock, // clock
  input wire logic srst, // reset
  input wire logic csN, // select
  input wire logic holdN, // hold
  input wire logic soOe, // out enable
  input wire logic memWrReq, // mem request
  input wire logic [15:0] memWrAddr, // mem address
  input wire logic memWrStore, // stored
  input wire logic memWrDrop, // dropped
  input wire logic statusWrReq, // status request
  input wire nvram_ctl_pkg::status_t statusWrData, // status data
  input wire logic statusWrDone, // written
  input wire logic statusWrDrop, // refused
  input wire nvram_ctl_pkg::status_t statusByte, // status
  input wire logic sleeping, // asleep
  input wire logic holdAbort // abort
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  // --------
  // helpers
  // --------
  logic [1:0] bp;
  logic prot;
  logic [31:0] wakeCnt_q;
  logic [31:0] wakeCnt_d;
  // protected range decode and wake counter
  assign bp = {statusByte.blockProtectHigh, statusByte.blockProtectLow};
  assign prot = bp == 2'h3 || (bp == 2'h2 && memWrAddr[15])
    || (bp == 2'h1 && memWrAddr[15:14] == 2'h3);
  assign wakeCnt_d = !sleeping ? 32'h0 :
    (wakeCnt_q != 32'h0 || !csN) ? wakeCnt_q + 32'h1 : wakeCnt_q;
  // counts cycles from the first select seen in sleep
  always_ff @(posedge clock) begin
    if (srst) wakeCnt_q <= 32'h0;
    else wakeCnt_q <= wakeCnt_d;
  end
  sequence memAnswer; memWrStore ^ memWrDrop; endsequence
  sequence statusAnswer; statusWrDone ^ statusWrDrop; endsequence
  sequence heldRise; $rose(csN) && !holdN; endsequence
  // --------
  // checks
  // --------
  mem_answer_a: assert property (memWrReq |=> memAnswer)
    else $error("memory write answer missing");
  answer_cause_a: assert property (
    memWrStore || memWrDrop |-> $past(memWrReq))
    else $error("memory answer without request");
  latch_gate_a: assert property (
    memWrReq && !statusByte.writeEnableLatch |=> memWrDrop)
    else $error("write passed with latch clear");
  block_map_a: assert property (
    memWrReq && statusByte.writeEnableLatch |=> memWrDrop == $past(prot))
    else $error("block protect decode wrong");
  status_gate_a: assert property (
    statusWrReq && !statusByte.writeEnableLatch |=> statusWrDrop)
    else $error("status write passed with latch clear");
  status_answer_a: assert property (statusWrReq |=> statusAnswer)
    else $error("status write answer missing");
  status_load_a: assert property (
    statusWrDone |-> statusByte[7:2] == $past(statusWrData[7:2]))
    else $error("status bits not loaded");
  asleep_float_a: assert property (sleeping |-> !soOe)
    else $error("output driven in sleep");
  deselect_float_a: assert property (csN |-> !soOe)
    else $error("output driven while deselected");
  wake_clear_a: assert property (
    $fell(sleeping) |-> !statusByte.writeEnableLatch)
    else $error("latch kept over wake");
  wake_bound_a: assert property (wakeCnt_q <= WakeCycles)
    else $error("wake took too long");
  held_abort_a: assert property (heldRise |-> ##[2:8] holdAbort)
    else $error("no abort on deselect in hold");
endmodule

bind spi_nvram_protect_sleep_hold nvram_ctl_asserts #(
  .WakeCycles(WakeCycles)
) i_chk (
  .clock(clock), .srst(srst), .csN(csN), .holdN(holdN), .soOe(soOe),
  .memWrReq(memWrReq), .memWrAddr(memWrAddr), .memWrStore(memWrStore),
  .memWrDrop(memWrDrop), .statusWrReq(statusWrReq),
  .statusWrData(statusWrData), .statusWrDone(statusWrDone),
  .statusWrDrop(statusWrDrop), .statusByte(statusByte),
  .sleeping(sleeping), .holdAbort(holdAbort)
);

// *** bench/spi_host_model.sv ***
// serial host model driving select, clock, data and hold
`timescale 1ns/1ps
module spi_host_model (
  output logic csN, // select, idle high
  output logic sclk, // clock, still between frames
  output logic si, // serial data
  output logic holdN, // hold, idle high
  input wire logic soOut // data from device
);
  logic [31:0] rxWord;
  // idle levels, mode 0
  initial begin
    csN = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
    holdN = 1'b1;
  end
  // one clock: data, sample output, rise, fall
  task automatic tick(input logic d);
    si = d;
    #6;
    rxWord = {rxWord[30:0], soOut};
    sclk = 1'b1;
    #6;
    sclk = 1'b0;
  endtask
  // hold at clock low, wiggle clock and data, release at clock low
  task automatic hold();
    #6 holdN = 1'b0;
    repeat (3) begin
      #6 sclk = 1'b1;
      si = ~si;
      #6 sclk = 1'b0;
    end
    #6 holdN = 1'b1;
  endtask
  // opcode then extra clocks with a toggling data line
  task automatic frame(input logic [7:0] op, input int extra, input int hAt);
    csN = 1'b0;
    #6;
    for (int i = 7; i >= 0; i--) tick(op[i]);
    for (int i = 0; i < extra; i++) begin
      if (i == hAt) hold();
      tick(~si);
    end
    #6 csN = 1'b1;
    #48; // deselect time before the next frame
  endtask
  // deselect while held inside an opcode
  task automatic abort();
    csN = 1'b0;
    for (int i = 0; i < 4; i++) tick(1'b0);
    holdN = 1'b0;
    #6 csN = 1'b1;
    #200 holdN = 1'b1;
  endtask
  // wake edge, early deselect allowed
  task automatic wake();
    csN = 1'b0;
    #30 csN = 1'b1;
  endtask
endmodule

// *** bench/tb.sv ***
// self-checking bench for the nvram control slice
`timescale 1ns/1ps
module tb;
  localparam int unsigned Wake = 20;
  logic clock, srst, welSet, welClr, statusWrReq, memWrReq, wpN;
  logic sclk, csN, si, holdN, soOut, soOe, memWrStore, memWrDrop;
  logic statusWrDone, statusWrDrop, sleeping, holdAbort;
  logic [15:0] memWrAddr;
  logic [1:0] flag;
  nvram_ctl_pkg::status_t statusWrData, statusByte;
  logic [15:0] adr [6] = '{16'h0000, 16'h7FFF, 16'h8000, 16'hBFFF,
    16'hC000, 16'hFFFF};
  int errors, compares;
  assign flag = {holdAbort, sleeping};
  initial clock = 1'b0;
  always #5 clock = ~clock;
  spi_nvram_protect_sleep_hold #(.WakeCycles(Wake)) i_dut (
    .clock(clock), .srst(srst), .sclk(sclk), .csN(csN), .si(si),
    .holdN(holdN), .wpN(wpN), .soOut(soOut), .soOe(soOe),
    .welSet(welSet), .welClr(welClr), .statusWrReq(statusWrReq),
    .statusWrData(statusWrData), .memWrReq(memWrReq),
    .memWrAddr(memWrAddr), .memWrStore(memWrStore),
    .memWrDrop(memWrDrop), .statusWrDone(statusWrDone),
    .statusWrDrop(statusWrDrop), .statusByte(statusByte),
    .sleeping(sleeping), .holdAbort(holdAbort));
  spi_host_model i_host (.csN(csN), .sclk(sclk), .si(si),
    .holdN(holdN), .soOut(soOut));
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // verdict and end of run
  task automatic test_done();
    if (errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // one memory or status write, answer one cycle later
  task automatic wr(input logic st, input logic [15:0] a, input logic ok);
    @(posedge clock);
    memWrReq <= !st;
    statusWrReq <= st;
    memWrAddr <= a;
    statusWrData <= a[7:0];
    @(posedge clock);
    memWrReq <= 1'b0;
    statusWrReq <= 1'b0;
    #1;
    check(st ? statusWrDone : memWrStore, ok);
    check(st ? statusWrDrop : memWrDrop, !ok);
  endtask
  // latch set or clear pulse
  task automatic setw(input logic s);
    @(posedge clock);
    welSet <= s;
    welClr <= !s;
    @(posedge clock);
    welSet <= 1'b0;
    welClr <= 1'b0;
  endtask
  // bounded wait for a flag level
  task automatic waitFor(input int k, input logic v, input int n);
    int i;
    for (i = 0; i < n && flag[k] !== v; i++) begin
      @(posedge clock);
      #1;
    end
    check(i < n, 1'b1);
  endtask
  // main sequence
  initial begin
    logic ok;
    errors = 0;
    compares = 0;
    {srst, welSet, welClr, statusWrReq, memWrReq, wpN} = 6'h21;
    memWrAddr = 16'h0000;
    statusWrData = 8'h00;
    repeat (4) @(posedge clock);
    srst <= 1'b0;
    #1 check(statusByte, 8'h00);
    setw(1'b1);
    setw(1'b0);
    wr(1'b0, 16'h0000, 1'b0);
    wr(1'b1, 16'h00FC, 1'b0);
    setw(1'b1);
    for (int b = 0; b < 4; b++) begin
      wr(1'b1, {12'h000, b[1:0], 2'h3}, 1'b1);
      check(statusByte, {4'h0, b[1:0], 2'h2});
      for (int k = 0; k < 6; k++) begin
        ok = !(b == 3 || (b == 2 && adr[k][15])
          || (b == 1 && adr[k][15:14] == 2'h3));
        wr(1'b0, adr[k], ok);
      end
    end
    wr(1'b1, 16'h0080, 1'b1);
    @(posedge clock) wpN <= 1'b0;
    repeat (6) @(posedge clock);
    wr(1'b1, 16'h0000, 1'b0);
    check(statusByte, 8'h82);
    @(posedge clock) wpN <= 1'b1;
    repeat (6) @(posedge clock);
    wr(1'b1, 16'h0000, 1'b1);
    i_host.frame(nvram_ctl_pkg::OPC_IDENTITY, 34, 99);
    check(i_host.rxWord, {nvram_ctl_pkg::ID_WORD[29:0],
      {2{nvram_ctl_pkg::ID_WORD[0]}}});
    i_host.frame(nvram_ctl_pkg::OPC_IDENTITY, 32, 12);
    check(i_host.rxWord, nvram_ctl_pkg::ID_WORD);
    fork
      i_host.abort();
      waitFor(1, 1'b1, 60);
    join
    check(statusByte.writeEnableLatch, 1'b1);
    i_host.frame(nvram_ctl_pkg::OPC_SLEEP, 1, 99);
    repeat (15) @(posedge clock);
    check(sleeping, 1'b0);
    i_host.frame(nvram_ctl_pkg::OPC_SLEEP, 0, 99);
    waitFor(0, 1'b1, 12);
    fork
      i_host.wake();
      waitFor(0, 1'b0, Wake + 1);
    join
    check(statusByte.writeEnableLatch, 1'b0);
    test_done();
  end
  // watchdog well beyond the few microseconds the tests need
  initial begin
    #50us;
    errors++;
    test_done();
  end
endmodule
